// *** logic/lpsc_pkg.sv ***
// Purpose: shared constants and types for the low power state control
// Assumes: one clock, sys_clk at 200 MHz
// Notes: timing counts derived from the bus clock rate
package lpsc_pkg;
  // states of the power sequencer
  typedef enum logic [2:0] {
    ST_RUN,
    ST_GRANT,
    ST_SLEEP,
    ST_DEEP,
    ST_MGMT_SAVE,
    ST_MGMT_ACK,
    ST_MGMT_RUN
  } lpsc_state_type;
  // bus transaction kinds issued on the special cycle port
  typedef enum logic [1:0] {
    TXN_NONE,
    TXN_GRANT_ACK,
    TXN_MGMT_ACK
  } lpsc_txn_type;
  // synchroniser depth, at least two flops
  localparam int SYNC_DEPTH = 2;
  // front bus outputs must drop within this many clocks of reset
  localparam int BUS_DROP_CLOCKS = 2;
  // cycles spent saving state before the acknowledge
  localparam int SAVE_CYCLES = 4;
  localparam logic [2:0] SAVE_LAST = 3'h3;
  localparam logic [2:0] SAVE_ZERO = 3'h0;
  // number of bus clock loss detection cycles
  localparam logic [3:0] BCLK_LOSS_LIMIT = 4'hF;
  localparam logic [3:0] BCLK_ZERO = 4'h0;
endpackage

// *** logic/lpsc_sync.sv ***
// Purpose: multi-flop level synchroniser for asynchronous inputs
// Assumes: inputs may change at any time relative to sys_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module lpsc_sync #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  // refuse a single-flop chain, it would not settle metastability
  if (DEPTH < 2) begin : g_bad
    $error("lpsc_sync needs DEPTH of at least 2");
  end
  // the flop chain, stage 0 catches the raw pin
  logic [WIDTH-1:0] stage_r [DEPTH];
  genvar i;
  for (i = 0; i < DEPTH; i++) begin : g_stage
    if (i == 0) begin : g_first
      always_ff @(posedge sys_clk) begin
        if (!nrst) stage_r[i] <= RST_VAL;
        else stage_r[i] <= d_in;
      end
    end else begin : g_next
      always_ff @(posedge sys_clk) begin
        if (!nrst) stage_r[i] <= RST_VAL;
        else stage_r[i] <= stage_r[i-1];
      end
    end
  end
  assign q_out = stage_r[DEPTH-1];
endmodule
`default_nettype wire

// *** logic/lpsc_ctrl.sv ***
// Purpose: processor power state and management interrupt sequencer
// Assumes: sideband request pins are asynchronous and active low
// Notes: clock gate enables are levels meant for an external clock gate
// Behaviour
// - grant plus sleep request enters sleep
// - sleep gates all unit clocks, pll stays
// - sleep ignores snoops and interrupts
// - sleep reacts to reset, sleep release, clock loss
// - sleep release returns to grant, restarts clocks
// - deep sleep request in sleep enters deep
// - management interrupt saves state, enters mgmt mode
// - acknowledge transaction, then run handler
// - mgmt interrupt at reset release tristates outputs
// - stop clock request enters grant state
// - grant entry from run issues grant acknowledge transaction
// - grant gates core clocks, bus and irq run
// - grant keeps snooping and servicing interrupts
// - stop clock release restarts clocks, resumes
// - stop clock asynchronous, bus clock untouched
// - reset drops bus outputs within two clocks
`timescale 1ns/1ps
`default_nettype none
module lpsc_ctrl #(
  parameter int SYNC_STAGES = lpsc_pkg::SYNC_DEPTH
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clock_halt_request_n,
  input wire logic sleep_request_n,
  input wire logic deep_sleep_request_n,
  input wire logic mgmt_interrupt_n,
  input wire logic bclk_alive,
  input wire logic snoop_req,
  input wire logic irq_req,
  input wire logic [7:0] bus_out_data,
  input wire logic bus_out_valid,
  output logic core_clk_en,
  output logic bus_clk_en,
  output logic irq_ctrl_clk_en,
  output logic pll_en,
  output logic snoop_accept,
  output logic irq_accept,
  output logic exec_en,
  output logic state_save,
  output logic system_management_mode,
  output logic txn_valid,
  output var lpsc_pkg::lpsc_state_type state,
  output var lpsc_pkg::lpsc_txn_type txn_kind,
  output logic deep_sleep,
  output logic [7:0] bus_pin_out,
  output logic bus_pin_oe_n
);
  import lpsc_pkg::*;
  // refuse a chain too short to settle, or too long for the window count
  if (SYNC_STAGES < 2 || SYNC_STAGES > 14) begin : g_bad
    $error("lpsc_ctrl needs SYNC_STAGES between 2 and 14");
  end

  // synchronised request levels, still active low
  logic [3:0] req_sync_n;
  logic halt_req; // stop clock asked
  logic sleep_req; // sleep asked
  logic deep_req; // deep sleep asked
  logic mgmt_req; // management interrupt asked

  // all asynchronous sideband pins cross here first
  lpsc_sync #(
    .WIDTH(4),
    .DEPTH(SYNC_STAGES),
    .RST_VAL(4'hF)
  ) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .d_in({mgmt_interrupt_n, deep_sleep_request_n, sleep_request_n,
           clock_halt_request_n}),
    .q_out(req_sync_n)
  );
  // stop clock is only ever sampled, never used as a clock
  assign halt_req = ~req_sync_n[0];
  assign sleep_req = ~req_sync_n[1];
  assign deep_req = ~req_sync_n[2];
  assign mgmt_req = ~req_sync_n[3];

  // state and helper registers
  lpsc_state_type state_r, state_nxt;
  logic [2:0] save_cnt_r, save_cnt_nxt; // state save progress
  logic [3:0] bclk_lost_r; // cycles without bus clock activity
  logic bclk_lost; // bus clock considered removed
  logic mgmt_pend_r; // interrupt latched, not yet accepted
  logic tristate_r; // outputs parked after reset release
  logic [3:0] since_rst_r; // edges since reset release, saturating
  logic in_rst_win; // pin level at release still crossing the chain
  // the chain resets to idle, so the pin level at release needs this long
  localparam logic [3:0] RST_WIN_END = 4'(SYNC_STAGES + 1);
  logic [7:0] bus_pin_r; // registered bus output data
  logic bus_oe_n_r; // registered bus output enable, low drives
  lpsc_txn_type txn_r, txn_nxt; // special cycle being issued

  // bus clock loss watchdog, a stand-in for a missing clock detector
  always_ff @(posedge sys_clk) begin
    if (!nrst) bclk_lost_r <= BCLK_ZERO;
    else if (bclk_alive) bclk_lost_r <= BCLK_ZERO;
    else if (bclk_lost_r != BCLK_LOSS_LIMIT) bclk_lost_r <= bclk_lost_r + 4'h1;
  end
  assign bclk_lost = (bclk_lost_r == BCLK_LOSS_LIMIT);

  // capture a management request at reset release
  // the window spans the chain's latency, since it resets to idle
  assign in_rst_win = (since_rst_r != RST_WIN_END);
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      since_rst_r <= 4'h0;
      tristate_r <= 1'b0;
    end else begin
      if (in_rst_win) since_rst_r <= since_rst_r + 4'h1;
      if (in_rst_win && mgmt_req) tristate_r <= 1'b1;
    end
  end

  // management interrupt latch; sleep states hold it off
  // set wins over the clear in the same cycle
  logic mgmt_take; // accept the latched interrupt now
  assign mgmt_take = mgmt_pend_r &&
    (state_r == ST_RUN || state_r == ST_GRANT);
  always_ff @(posedge sys_clk) begin
    if (!nrst) mgmt_pend_r <= 1'b0;
    else if (mgmt_req && state_r != ST_SLEEP && state_r != ST_DEEP &&
             !system_management_mode)
      mgmt_pend_r <= 1'b1; // ignored in sleep
    else if (mgmt_take) mgmt_pend_r <= 1'b0;
  end

  // next state logic
  always_comb begin
    state_nxt = state_r;
    save_cnt_nxt = save_cnt_r;
    txn_nxt = TXN_NONE;
    case (state_r)
      ST_RUN: begin
        if (mgmt_take) begin
          state_nxt = ST_MGMT_SAVE;
          save_cnt_nxt = SAVE_ZERO;
        end else if (halt_req) begin
          state_nxt = ST_GRANT;
          txn_nxt = TXN_GRANT_ACK;
        end
      end
      ST_GRANT: begin
        // interrupts still serviced here
        if (mgmt_take) begin
          state_nxt = ST_MGMT_SAVE;
          save_cnt_nxt = SAVE_ZERO;
        end else if (sleep_req) begin
          state_nxt = ST_SLEEP;
        end else if (!halt_req) begin
          state_nxt = ST_RUN;
        end
      end
      ST_SLEEP: begin
        // only sleep release, deep request and clock loss matter;
        // reset is handled by the clocked process
        if (!sleep_req) state_nxt = ST_GRANT;
        else if (deep_req || bclk_lost) state_nxt = ST_DEEP;
      end
      ST_DEEP: begin
        // leave only when the deep request and clock loss are gone
        if (!deep_req && !bclk_lost) state_nxt = ST_SLEEP;
      end
      ST_MGMT_SAVE: begin
        save_cnt_nxt = save_cnt_r + 3'h1;
        if (save_cnt_r == SAVE_LAST) begin
          state_nxt = ST_MGMT_ACK;
          txn_nxt = TXN_MGMT_ACK;
        end
      end
      ST_MGMT_ACK: begin
        state_nxt = ST_MGMT_RUN; // handler starts after the ack
      end
      ST_MGMT_RUN: begin
        // handler runs until reset; no resume path exists in the project
        state_nxt = ST_MGMT_RUN;
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_r <= ST_RUN;
      save_cnt_r <= SAVE_ZERO;
      txn_r <= TXN_NONE;
    end else begin
      state_r <= state_nxt;
      save_cnt_r <= save_cnt_nxt;
      txn_r <= txn_nxt;
    end
  end

  // clock gate enables per state
  logic in_sleep; // sleep or deeper
  assign in_sleep = (state_r == ST_SLEEP) || (state_r == ST_DEEP);
  // core stops in grant and sleep
  assign core_clk_en = !in_sleep && state_r != ST_GRANT;
  // bus and interrupt units keep running in grant
  assign bus_clk_en = !in_sleep;
  assign irq_ctrl_clk_en = !in_sleep;
  // pll stays on through sleep, off only in deep sleep
  assign pll_en = (state_r != ST_DEEP);
  // snoops and interrupts accepted outside sleep
  assign snoop_accept = snoop_req && !in_sleep;
  assign irq_accept = irq_req && !in_sleep;
  // execution only when running
  assign exec_en = (state_r == ST_RUN) || (state_r == ST_MGMT_RUN);
  assign state_save = (state_r == ST_MGMT_SAVE);
  assign system_management_mode = (state_r == ST_MGMT_SAVE) ||
    (state_r == ST_MGMT_ACK) || (state_r == ST_MGMT_RUN);
  assign deep_sleep = (state_r == ST_DEEP);
  assign state = state_r;

  // special cycle outputs, one-cycle pulse
  assign txn_kind = txn_r;
  assign txn_valid = (txn_r != TXN_NONE);

  // front bus output stage; reset drops it on the first edge,
  // well inside the two-clock bound
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bus_pin_r <= 8'h00;
      bus_oe_n_r <= 1'b1;
    end else if (tristate_r || in_sleep || in_rst_win) begin
      // held off during the window so a late tristate never glitches
      bus_pin_r <= 8'h00; // parked
      bus_oe_n_r <= 1'b1;
    end else begin
      bus_pin_r <= bus_out_data;
      bus_oe_n_r <= !bus_out_valid;
    end
  end
  assign bus_pin_out = bus_pin_r;
  assign bus_pin_oe_n = bus_oe_n_r;
endmodule
`default_nettype wire

// *** dv/lpsc_ctrl_monitor.sv ***
// Purpose: port checker of the power state sequencer
// Assumes: one clock, sync active low reset
// Notes: bound to lpsc_ctrl at the foot
`timescale 1ns/1ps
`default_nettype none
module lpsc_ctrl_monitor (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic core_clk_en,
  input wire logic bus_clk_en,
  input wire logic irq_ctrl_clk_en,
  input wire logic snoop_req,
  input wire logic irq_req,
  input wire logic pll_en,
  input wire logic snoop_accept,
  input wire logic irq_accept,
  input wire logic exec_en,
  input wire logic state_save,
  input wire logic txn_valid,
  input wire lpsc_pkg::lpsc_state_type state,
  input wire lpsc_pkg::lpsc_txn_type txn_kind,
  input wire logic bus_pin_oe_n
);
  import lpsc_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  property p_gack; $past(state) == ST_RUN && state == ST_GRANT
    |-> txn_valid && txn_kind == TXN_GRANT_ACK; endproperty
  a_gack: assert property (p_gack) else $error("no grant ack");
  property p_gclk; state == ST_GRANT
    |-> !core_clk_en && bus_clk_en; endproperty
  a_gclk: assert property (p_gclk) else $error("grant gating");
  // grant still serves snoops and interrupts
  property p_gsvc; state == ST_GRANT |-> irq_ctrl_clk_en &&
    snoop_accept == snoop_req && irq_accept == irq_req; endproperty
  a_gsvc: assert property (p_gsvc) else $error("grant service");
  property p_sclk; state == ST_SLEEP
    |-> !core_clk_en && !bus_clk_en && pll_en; endproperty
  a_sclk: assert property (p_sclk) else $error("sleep gating");
  property p_sign; state == ST_SLEEP
    |-> !snoop_accept && !irq_accept; endproperty
  a_sign: assert property (p_sign) else $error("sleep accepts");
  // sleep may only be left towards grant or deep sleep
  property p_sexit; $past(state) == ST_SLEEP
    |-> state inside {ST_SLEEP, ST_GRANT, ST_DEEP}; endproperty
  a_sexit: assert property (p_sexit) else $error("sleep exit");
  // save lasts four cycles, then the acknowledge goes out
  property p_save; $rose(state_save) |-> state_save[*4]
    ##1 txn_valid && txn_kind == TXN_MGMT_ACK; endproperty
  a_save: assert property (p_save) else $error("save");
  property p_run; $past(state) == ST_GRANT && state == ST_RUN
    |-> core_clk_en && exec_en; endproperty
  a_run: assert property (p_run) else $error("no resume");
  // reset itself is the antecedent, so no disable here
  property p_drop; disable iff (1'b0) !nrst ##1 !nrst
    |-> bus_pin_oe_n; endproperty
  a_drop: assert property (p_drop) else $error("bus held");
endmodule
bind lpsc_ctrl lpsc_ctrl_monitor i_lpsc_ctrl_monitor (.sys_clk, .nrst,
  .core_clk_en, .bus_clk_en, .irq_ctrl_clk_en, .snoop_req, .irq_req,
  .pll_en, .snoop_accept, .irq_accept, .exec_en,
  .state_save, .txn_valid, .state, .txn_kind, .bus_pin_oe_n);
`default_nettype wire

// *** dv/lpsc_chipset_model.sv ***
// Purpose: chipset model for the power request pins
// Assumes: pins move on the falling edge
// Notes: release runs deep, sleep, then halt
`timescale 1ns/1ps
`default_nettype none
module lpsc_chipset_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic want_deep,
  input wire logic txn_valid,
  input wire lpsc_pkg::lpsc_txn_type txn_kind,
  output logic clock_halt_request_n,
  output logic sleep_request_n,
  output logic deep_sleep_request_n
);
  import lpsc_pkg::*;
  logic ack_r = 1'b0; // grant acknowledge seen
  initial {clock_halt_request_n, sleep_request_n, deep_sleep_request_n} = '1;
  // sleep waits for the acknowledge; halt waits for sleep release
  always @(negedge sys_clk) begin
    if (txn_valid && txn_kind == TXN_GRANT_ACK) ack_r <= 1'b1;
    if (go) begin
      clock_halt_request_n <= 1'b0;
      if (ack_r) sleep_request_n <= 1'b0;
      deep_sleep_request_n <= !(want_deep && !sleep_request_n);
    end else begin
      deep_sleep_request_n <= 1'b1;
      sleep_request_n <= sleep_request_n | deep_sleep_request_n;
      clock_halt_request_n <= sleep_request_n;
      ack_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** dv/lpsc_tb.sv ***
// Purpose: self-checking bench of the power state sequencer
// Assumes: chipset model drives the request pins
// Notes: bus clock kept alive except once while asleep, to exercise clock loss
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lpsc_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, go = 1'b0, want_deep = 1'b0;
  logic mgmt_interrupt_n = 1'b1, snoop_req = 1'b0, irq_req = 1'b0;
  logic bus_out_valid = 1'b0, bclk_alive = 1'b1;
  logic [7:0] bus_out_data = 8'h00, bus_pin_out;
  logic clock_halt_request_n, sleep_request_n, deep_sleep_request_n;
  logic core_clk_en, bus_clk_en, irq_ctrl_clk_en, pll_en, snoop_accept;
  logic irq_accept, exec_en, state_save, system_management_mode;
  logic txn_valid, deep_sleep, bus_pin_oe_n;
  lpsc_state_type state;
  lpsc_txn_type txn_kind;
  lpsc_txn_type exp_q[$]; // expected transactions, oldest first
  int fail_count = 0, n_tests = 0, seed = 38;
  lpsc_ctrl i_lpsc_ctrl (.*);
  lpsc_chipset_model i_lpsc_chipset_model (.*);
  initial forever #2.5 sys_clk = ~sys_clk;
  // random bus data, snoops and interrupts off the sampling edge
  always @(negedge sys_clk)
    {bus_out_data, bus_out_valid, snoop_req, irq_req} <= 11'($random(seed));
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait; a miss ends the run
  task automatic wait_state(lpsc_state_type s);
    int i;
    for (i = 0; i < 80 && state !== s; i++) @(negedge sys_clk);
    chk("state", 8'(s), 8'(state));
    if (state !== s) final_report();
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // each issued transaction is held against the oldest note
  always @(negedge sys_clk)
    if (nrst && txn_valid !== 1'b0) begin
      if (exp_q.size() == 0)
        chk("txn_kind", 8'(TXN_NONE), 8'(txn_kind));
      else
        chk("txn_kind", 8'(exp_q.pop_front()), 8'(txn_kind));
    end
  initial begin
    repeat (10) @(negedge sys_clk);
    chk("bus_pin_oe_n", 8'h01, 8'(bus_pin_oe_n));
    nrst = 1'b1;
    exp_q.push_back(TXN_GRANT_ACK);
    go = 1'b1;
    wait_state(ST_SLEEP);
    // interrupt while asleep must be ignored
    mgmt_interrupt_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk("state", 8'(ST_SLEEP), 8'(state));
    mgmt_interrupt_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    want_deep = 1'b1;
    wait_state(ST_DEEP);
    chk("pll_en", 8'h00, 8'(pll_en));
    want_deep = 1'b0;
    wait_state(ST_SLEEP);
    // bus clock loss while asleep also leads to deep sleep
    bclk_alive = 1'b0;
    wait_state(ST_DEEP);
    chk("deep_sleep", 8'h01, 8'(deep_sleep));
    bclk_alive = 1'b1;
    wait_state(ST_SLEEP);
    go = 1'b0;
    wait_state(ST_RUN);
    exp_q.push_back(TXN_MGMT_ACK);
    mgmt_interrupt_n = 1'b0;
    wait_state(ST_MGMT_RUN);
    // second reset in mid-run, handler mode must be left
    mgmt_interrupt_n = 1'b1;
    nrst = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk("bus_pin_oe_n", 8'h01, 8'(bus_pin_oe_n));
    chk("smm", 8'h00, 8'(system_management_mode));
    nrst = 1'b1;
    wait_state(ST_RUN);
    // management request held across reset release parks the bus
    exp_q.push_back(TXN_MGMT_ACK);
    nrst = 1'b0;
    mgmt_interrupt_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (12) begin
      @(negedge sys_clk);
      chk("bus_pin_oe_n", 8'h01, 8'(bus_pin_oe_n));
    end
    wait_state(ST_MGMT_RUN);
    chk("exp_q", 8'h00, 8'(exp_q.size()));
    final_report();
  end
endmodule
`default_nettype wire
